// file: src/posstat_pkg.sv
package posstat_pkg;

    // widths
    localparam int STEP_W   = 32;
    localparam int MICROSTEP_COUNT_W  = 16;
    localparam int ENC_W    = 32;

    // motion command codes held in the command progress word
    typedef enum logic [3:0] {
        CMD_UNKNOWN   = 4'h0,
        CMD_ABS_MOVE  = 4'h1,
        CMD_REL_SHIFT = 4'h2,
        CMD_RUN_POS   = 4'h3,
        CMD_RUN_NEG   = 4'h4,
        CMD_SMOOTH    = 4'h5,
        CMD_FAST_STOP = 4'h6,
        CMD_HOME      = 4'h7,
        CMD_BACKLASH  = 4'h8
    } motion_cmd_e;

    // command progress word layout: [3:0] code, [4] running, [5] success
    localparam int CPW_CODE_LSB   = 0;
    localparam int CPW_RUN_BIT    = 4;
    localparam int CPW_OK_BIT     = 5;
    localparam int CPW_W          = 6;

    // motion flags word layout
    localparam int MFW_MOVING_BIT = 0;
    localparam int MFW_SPEED_BIT  = 1;
    localparam int MFW_BACKL_BIT  = 2;
    localparam int MFW_W          = 3;

    typedef enum logic [1:0] {
        PWR_OFF, PWR_REDUCED, PWR_NOMINAL, PWR_LOW_SUPPLY
    } power_state_e;

    typedef enum logic [2:0] {
        ENC_ABSENT, ENC_UNKNOWN, ENC_OK, ENC_REVERSED, ENC_DEFECT
    } enc_state_e;

    typedef enum logic [1:0] {
        COIL_UNKNOWN, COIL_OPEN, COIL_CONNECTED, COIL_SHORTED
    } coil_state_e;

    // encoder statistics
    localparam int ENC_SAMPLES_DEF   = 64;
    localparam int ENC_BAD_LIMIT_DEF = 16;
    localparam int ENC_CNT_W         = 8;

    // coil classification thresholds (arbitrary units of measurement)
    localparam logic [15:0] COIL_SHORT_R_DEF = 16'h0002;
    localparam logic [15:0] COIL_SHORT_L_DEF = 16'h0002;
    localparam logic [15:0] COIL_OPEN_R_DEF  = 16'hF000;

endpackage : posstat_pkg

// file: src/encoder_health.sv
`timescale 1ns/1ps
module encoder_health
    import posstat_pkg::*;
#(
    parameter int SAMPLES   = ENC_SAMPLES_DEF,
    parameter int BAD_LIMIT = ENC_BAD_LIMIT_DEF
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       encPresent,
    input  wire logic       feedbackOn,
    input  wire logic       moving,
    input  wire logic       rotorStep,
    input  wire logic       rotorDirPos,
    input  wire logic       encStep,
    input  wire logic       encDirPos,
    output enc_state_e      state
);

    typedef struct packed {
        enc_state_e             cls;
        logic [ENC_CNT_W-1:0]   samples;
        logic [ENC_CNT_W-1:0]   agree;
        logic [ENC_CNT_W-1:0]   reversed;
        logic [ENC_CNT_W-1:0]   quiet;
    } health_s;

    health_s r;
    health_s next_r;

    // =========================================================
    // statistics, only while moving
    always_comb begin
        next_r = r;
        if (!encPresent) begin
            next_r = '0;
            next_r.cls = ENC_ABSENT;
        end else if (feedbackOn) begin
            next_r.cls = ENC_UNKNOWN;
        end else if (moving && rotorStep) begin
            next_r.samples = r.samples + 8'(1);
            if (!encStep)
                next_r.quiet = r.quiet + 8'(1);
            else if (encDirPos == rotorDirPos)
                next_r.agree = r.agree + 8'(1);
            else
                next_r.reversed = r.reversed + 8'(1);
            // decide only after a full sample window
            if (r.samples == 8'(SAMPLES - 1)) begin
                if (r.quiet >= 8'(BAD_LIMIT)
                    || (r.agree >= 8'(BAD_LIMIT)
                        && r.reversed >= 8'(BAD_LIMIT)))
                    next_r.cls = ENC_DEFECT;
                else if (r.reversed > r.agree)
                    next_r.cls = ENC_REVERSED;
                else
                    next_r.cls = ENC_OK;
                next_r.samples  = '0;
                next_r.agree    = '0;
                next_r.reversed = '0;
                next_r.quiet    = '0;
            end
        end else if (r.cls == ENC_ABSENT) begin
            next_r.cls = ENC_UNKNOWN;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r     <= '0;
            r.cls <= ENC_ABSENT;
        end else begin
            r <= next_r;
        end
    end

    assign state = r.cls;

endmodule : encoder_health

// file: src/position_counters_and_motion_status.sv
`timescale 1ns/1ps
module position_counters_and_motion_status
    import posstat_pkg::*;
#(
    parameter int          SAMPLES      = ENC_SAMPLES_DEF,
    parameter int          BAD_LIMIT    = ENC_BAD_LIMIT_DEF,
    parameter logic [15:0] SHORT_R      = COIL_SHORT_R_DEF,
    parameter logic [15:0] SHORT_L      = COIL_SHORT_L_DEF,
    parameter logic [15:0] OPEN_R       = COIL_OPEN_R_DEF
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    // commands from the interpreter
    input  wire logic                       setZeroCmd,
    input  wire logic                       preset_counters_cmd,
    input  wire logic                       presetIgnoreStep,
    input  wire logic                       presetIgnoreEnc,
    input  wire logic signed [STEP_W-1:0]   presetStep,
    input  wire logic signed [MICROSTEP_COUNT_W-1:0]  presetMicro,
    input  wire logic signed [ENC_W-1:0]    presetEnc,
    input  wire logic                       motionCmdValid,
    input  wire logic [3:0]                 motionCmdCode,
    input  wire logic signed [STEP_W-1:0]   cmdTarget,
    input  wire logic                       shiftModeOn,
    input  wire logic signed [STEP_W-1:0]   shiftTarget,
    // manual controls
    input  wire logic                       joyEnable,
    input  wire logic                       joyPos,
    input  wire logic                       joyNeg,
    // motion engine
    input  wire logic                       stepPulse,
    input  wire logic                       stepDirPos,
    input  wire logic                       microPulse,
    input  wire logic                       encPulse,
    input  wire logic                       encDirPos,
    input  wire logic                       moving,
    input  wire logic [15:0]                curSpeed,
    input  wire logic [15:0]                setSpeed,
    input  wire logic                       backlashActive,
    input  wire logic                       motionDone,
    input  wire logic                       targetReached,
    input  wire logic                       leadingEncMode,
    // analog classification inputs
    input  wire logic                       windingEnable,
    input  wire logic                       currentReduced,
    input  wire logic                       supplyShort,
    input  wire logic [15:0]                coilR0,
    input  wire logic [15:0]                coilL0,
    input  wire logic                       coilValid0,
    input  wire logic [15:0]                coilR1,
    input  wire logic [15:0]                coilL1,
    input  wire logic                       coilValid1,
    input  wire logic                       encPresent,
    input  wire logic                       feedbackOn,
    // status outputs
    output logic signed [STEP_W-1:0]        primary_position_count,
    output logic signed [MICROSTEP_COUNT_W-1:0]       microstep_count,
    output logic signed [ENC_W-1:0]         encoderCount,
    output logic signed [STEP_W-1:0]        moveTarget,
    output logic signed [STEP_W-1:0]        shiftDest,
    output logic [MFW_W-1:0]                motion_flags_word,
    output logic [CPW_W-1:0]                command_progress_word,
    output power_state_e                    winding_power_state,
    output enc_state_e                      encoder_health_state,
    output coil_state_e [1:0]               coil_connection_state,
    output logic                            issueCmdValid,
    output logic [3:0]                      issueCmdCode
);

    typedef struct packed {
        logic signed [STEP_W-1:0]   step;
        logic signed [MICROSTEP_COUNT_W-1:0]  micro;
        logic signed [ENC_W-1:0]    enc;
        logic signed [STEP_W-1:0]   target;
        logic signed [STEP_W-1:0]   shift;
        logic [MFW_W-1:0]           flags;
        logic [3:0]                 code;
        logic                       running;
        logic                       ok;
        logic                       joyPosQ;
        logic                       joyNegQ;
        logic                       joyPosS;
        logic                       joyNegS;
        logic                       joyIssue;
        logic [3:0]                 joyCode;
        logic                       lastDefl;
        power_state_e               pwr;
        coil_state_e [1:0]          coil;
    } state_s;

    state_s r;
    state_s next_r;
    enc_state_e encState;

    // =========================================================
    // helpers
    function automatic coil_state_e classify(
        input logic [15:0] res,
        input logic [15:0] ind,
        input logic        valid
    );
        if (!valid)
            return COIL_UNKNOWN;
        else if (res <= SHORT_R && ind <= SHORT_L)
            return COIL_SHORTED;
        else if (res >= OPEN_R)
            return COIL_OPEN;
        else
            return COIL_CONNECTED;
    endfunction : classify

    function automatic logic signed [STEP_W-1:0] step_delta(
        input logic pulse,
        input logic dirPos
    );
        if (!pulse)
            return '0;
        return dirPos ? STEP_W'(1) : -STEP_W'(1);
    endfunction : step_delta

    // =========================================================
    // state update
    logic signed [STEP_W-1:0] advStep;
    logic signed [ENC_W-1:0]  advEnc;
    logic                     deflected;

    always_comb begin
        next_r    = r;
        // counters advance with the motion engine first
        advStep   = r.step + step_delta(stepPulse, stepDirPos);
        advEnc    = r.enc + ENC_W'(step_delta(encPulse, encDirPos));
        next_r.step = leadingEncMode ? advEnc : advStep;
        if (leadingEncMode)
            next_r.micro = '0;
        else if (microPulse)
            next_r.micro = stepDirPos ? r.micro + MICROSTEP_COUNT_W'(1)
                                      : r.micro - MICROSTEP_COUNT_W'(1);
        next_r.enc = advEnc;

        // set-zero: all counters cleared and targets rebased in the same cycle
        if (setZeroCmd) begin
            next_r.step   = '0;
            next_r.micro  = '0;
            next_r.enc    = '0;
            // physical destination kept by subtracting the position
            next_r.target = r.target - advStep;
            next_r.shift  = r.shift - advStep;
        end else if (preset_counters_cmd) begin
            if (!presetIgnoreStep) begin
                next_r.step   = presetStep;
                next_r.micro  = leadingEncMode ? '0 : presetMicro;
                // rebase target so the physical end stays put
                next_r.target = r.target + (presetStep - advStep);
                next_r.shift  = r.shift + (presetStep - advStep);
            end // target keeps its physical meaning, not zeroed
            if (!presetIgnoreEnc)
                next_r.enc = presetEnc;
        end

        if (motionCmdValid && motionCmdCode == 4'(CMD_ABS_MOVE))
            next_r.target = cmdTarget;
        else if (motionCmdValid && motionCmdCode == 4'(CMD_REL_SHIFT))
            next_r.target = next_r.target + cmdTarget;
        if (shiftModeOn && motionCmdValid && !setZeroCmd)
            next_r.shift = shiftTarget;

        // motion flags captured together
        next_r.flags[MFW_MOVING_BIT] = moving;
        next_r.flags[MFW_SPEED_BIT]  = moving && (curSpeed == setSpeed);
        next_r.flags[MFW_BACKL_BIT]  = backlashActive;

        // command progress word
        if (motionCmdValid) begin
            next_r.code    = motionCmdCode;
            next_r.running = 1'b1;
            next_r.ok      = 1'b1;
        end else if (joyIssue_w()) begin
            next_r.code    = r.joyCode;
            next_r.running = 1'b1;
            next_r.ok      = 1'b1;
        end else if (motionDone && r.running) begin
            next_r.running = 1'b0;
            next_r.ok      = targetReached;
        end

        // joystick, synchronised, issues ordinary commands on change
        next_r.joyPosQ  = joyPos;
        next_r.joyNegQ  = joyNeg;
        next_r.joyPosS  = r.joyPosQ;
        next_r.joyNegS  = r.joyNegQ;
        deflected       = r.joyPosS ^ r.joyNegS;
        next_r.joyIssue = 1'b0;
        if (joyEnable && (deflected != r.lastDefl
            || (deflected && r.joyCode != (r.joyPosS ? 4'(CMD_RUN_POS)
                                                     : 4'(CMD_RUN_NEG))))) begin
            next_r.joyIssue = 1'b1;
            next_r.joyCode  = !deflected ? 4'(CMD_SMOOTH)
                            : r.joyPosS  ? 4'(CMD_RUN_POS)
                                         : 4'(CMD_RUN_NEG);
        end
        if (joyEnable)
            next_r.lastDefl = deflected;

        // power classification
        if (!windingEnable)
            next_r.pwr = PWR_OFF;
        else if (supplyShort)
            next_r.pwr = PWR_LOW_SUPPLY;
        else if (currentReduced)
            next_r.pwr = PWR_REDUCED;
        else
            next_r.pwr = PWR_NOMINAL;

        next_r.coil[0] = classify(coilR0, coilL0, coilValid0);
        next_r.coil[1] = classify(coilR1, coilL1, coilValid1);
    end

    // joystick command pending this cycle (issued last cycle)
    function automatic logic joyIssue_w();
        return r.joyIssue;
    endfunction : joyIssue_w

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r      <= '0;
            r.code <= 4'(CMD_UNKNOWN);
            r.ok   <= 1'b1;
            r.pwr  <= PWR_OFF;
            r.joyCode <= 4'(CMD_SMOOTH);
        end else begin
            r <= next_r;
        end
    end

    // =========================================================
    // encoder classification
    encoder_health #(
        .SAMPLES    (SAMPLES),
        .BAD_LIMIT  (BAD_LIMIT)
    ) u_enc (
        .clock      (clock),
        .rst        (rst),
        .encPresent (encPresent),
        .feedbackOn (feedbackOn),
        .moving     (moving),
        .rotorStep  (stepPulse),
        .rotorDirPos(stepDirPos),
        .encStep    (encPulse),
        .encDirPos  (encDirPos),
        .state      (encState)
    );

    // =========================================================
    // outputs, all from registers
    assign primary_position_count = r.step;
    assign microstep_count        = r.micro;
    assign encoderCount           = r.enc;
    assign moveTarget             = r.target;
    assign shiftDest              = r.shift;
    assign motion_flags_word      = r.flags;
    assign command_progress_word  = {r.ok, r.running, r.code};
    assign winding_power_state    = r.pwr;
    assign encoder_health_state   = encState;
    assign coil_connection_state  = r.coil;
    assign issueCmdValid          = r.joyIssue;
    assign issueCmdCode           = r.joyCode;

endmodule : position_counters_and_motion_status

// file: verif/pcms_sva.sv
`timescale 1ns/1ps
// ==========================================
// counter and status checker
module pcms_sva
    import posstat_pkg::*;
(
    input wire logic                      clock,
    input wire logic                      rst,
    input wire logic                      setZeroCmd,
    input wire logic                      preset_counters_cmd,
    input wire logic                      presetIgnoreStep,
    input wire logic signed [STEP_W-1:0]  presetStep,
    input wire logic                      motionCmdValid,
    input wire logic [3:0]                motionCmdCode,
    input wire logic                      stepPulse,
    input wire logic                      moving,
    input wire logic [15:0]               curSpeed,
    input wire logic [15:0]               setSpeed,
    input wire logic                      backlashActive,
    input wire logic                      motionDone,
    input wire logic                      targetReached,
    input wire logic signed [STEP_W-1:0]  primary_position_count,
    input wire logic signed [MICROSTEP_COUNT_W-1:0] microstep_count,
    input wire logic signed [ENC_W-1:0]   encoderCount,
    input wire logic signed [STEP_W-1:0]  moveTarget,
    input wire logic signed [STEP_W-1:0]  shiftDest,
    input wire logic [MFW_W-1:0]          motion_flags_word,
    input wire logic [CPW_W-1:0]          command_progress_word,
    input wire logic                      issueCmdValid,
    input wire logic [3:0]                issueCmdCode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // a step on the same edge would make the offset ambiguous
    logic presetGo;
    assign presetGo = preset_counters_cmd && !setZeroCmd && !stepPulse
        && !motionCmdValid;

    AST_ZERO_CLEARS: assert property (
        setZeroCmd |=> primary_position_count == 0
        && microstep_count == 0 && encoderCount == 0)
        else $error("zero command left a counter set");
    AST_ZERO_REBASE: assert property (
        setZeroCmd && !stepPulse && !motionCmdValid |=>
        moveTarget == $past(moveTarget) - $past(primary_position_count)
        && shiftDest == $past(shiftDest) - $past(primary_position_count))
        else $error("zero command moved the physical target");
    AST_PRESET_LOAD: assert property (
        presetGo && !presetIgnoreStep |=>
        primary_position_count == $past(presetStep))
        else $error("preset step value not loaded");
    AST_PRESET_REBASE: assert property (
        presetGo |=> moveTarget == $past(moveTarget)
        + ($past(presetIgnoreStep) ? 0
        : $past(presetStep) - $past(primary_position_count)))
        else $error("preset moved the physical target");
    AST_FLAGS: assert property (
        1'b1 |=> motion_flags_word == {$past(backlashActive),
        $past(moving && curSpeed == setSpeed), $past(moving)})
        else $error("motion flags do not follow the motion");
    AST_CMD_CODE: assert property (
        motionCmdValid && !motionDone |=>
        command_progress_word[4:0] == {1'b1, $past(motionCmdCode)})
        else $error("command word missed a new command");
    AST_DONE_RESULT: assert property (
        motionDone && !motionCmdValid && !issueCmdValid
        && command_progress_word[CPW_RUN_BIT] |=>
        command_progress_word[5:4] == {$past(targetReached), 1'b0})
        else $error("command result wrong at completion");
    AST_JOY_CODES: assert property (
        issueCmdValid |-> issueCmdCode == CMD_RUN_POS
        || issueCmdCode == CMD_RUN_NEG || issueCmdCode == CMD_SMOOTH)
        else $error("manual control issued a foreign command");

    cover property (setZeroCmd && moving);
    cover property (presetGo && moving);
    cover property (motionDone && !targetReached);
endmodule : pcms_sva

bind position_counters_and_motion_status pcms_sva sva (.*);

// file: verif/motor_model.sv
`timescale 1ns/1ps
// ==========================================
// stepper with encoder, driven by the motion engine side
module motor_model #(
    parameter logic [15:0] SPEED = 16'h0010
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [7:0] steps,
    input  wire logic       reachOk,
    input  wire logic       encBroken,
    output logic            stepPulse,
    output logic            encPulse,
    output logic            moving,
    output logic [15:0]     curSpeed,
    output logic            backlashActive,
    output logic            motionDone,
    output logic            targetReached
);
    logic [7:0] left;
    logic [1:0] tail;
    // steps on alternate edges only, so quiet edges exist for commands
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {stepPulse, encPulse, moving, curSpeed, left, tail} <= '0;
            {backlashActive, motionDone, targetReached} <= '0;
        end else begin
            {stepPulse, encPulse, motionDone} <= 3'h0;
            if (go) begin
                left   <= steps;
                moving <= 1'b1;
            end else if (left != 8'h0) begin
                stepPulse <= !stepPulse;
                encPulse  <= !stepPulse && !encBroken;
                left      <= stepPulse ? left : left - 8'h1;
                tail      <= 2'h3;
                if (curSpeed < SPEED) curSpeed <= curSpeed + 16'h4;
            end else if (tail != 2'h0) begin
                tail           <= tail - 2'h1;
                backlashActive <= tail != 2'h1;
                moving         <= tail != 2'h1;
                motionDone     <= tail == 2'h1;
                targetReached  <= reachOk;
                curSpeed       <= '0;
            end
        end
    end
endmodule : motor_model

// file: verif/tb.sv
`timescale 1ns/1ps
module tb
    import posstat_pkg::*;
;
    logic clock, rst, setZeroCmd, preset_counters_cmd, presetIgnoreStep;
    logic presetIgnoreEnc, motionCmdValid, shiftModeOn, joyEnable, joyPos;
    logic joyNeg, stepDirPos, microPulse, encDirPos, leadingEncMode;
    logic windingEnable, currentReduced, supplyShort, coilValid0, coilValid1;
    logic encPresent, feedbackOn, go, reachOk, encBroken, stepPulse;
    logic encPulse, moving, backlashActive, motionDone, targetReached;
    logic issueCmdValid;
    logic signed [31:0] presetStep, presetEnc, cmdTarget, shiftTarget;
    logic signed [31:0] primary_position_count, encoderCount, moveTarget;
    logic signed [31:0] shiftDest;
    logic signed [15:0] presetMicro, microstep_count;
    logic [15:0] curSpeed, setSpeed, coilR0, coilL0, coilR1, coilL1;
    logic [7:0] steps;
    logic [3:0] motionCmdCode, issueCmdCode;
    logic [2:0] motion_flags_word, seen;
    logic [5:0] command_progress_word;
    power_state_e winding_power_state;
    enc_state_e encoder_health_state;
    coil_state_e [1:0] coil_connection_state;
    int fail_count, compares, stepsSeen, encSeen, z;
    localparam logic [2:0] PWR_IN [4] = '{3'h3, 3'h5, 3'h6, 3'h4};
    localparam power_state_e PWR_EXP [4] =
        '{PWR_OFF, PWR_LOW_SUPPLY, PWR_REDUCED, PWR_NOMINAL};

    position_counters_and_motion_status #(.SAMPLES(8), .BAD_LIMIT(2)) dut (.*);
    motor_model mdl (.*);

    always #20 clock = !clock;
    always @(posedge clock) begin
        stepsSeen += stepPulse;
        encSeen += encPulse;
        seen |= motion_flags_word;
    end

    // ==========================================
    // access tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic move(input logic [3:0] c, input logic [7:0] n);
        {motionCmdValid, motionCmdCode, cmdTarget} = {1'b1, c, 24'h0, n};
        {go, steps, stepsSeen, seen} = {n != 8'h0, n, 32'h0, 3'h0};
        tick(1);
        {motionCmdValid, go} = 2'h0;
        tick(1);
    endtask : move
    task automatic settle_move;
        for (int k = 0; k < 99 && motionDone !== 1'b1; k++) tick(1);
        tick(1);
    endtask : settle_move
    task automatic complete_run;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // ==========================================
    // tests
    initial begin
        {clock, setZeroCmd, preset_counters_cmd, presetIgnoreStep} = '0;
        {presetIgnoreEnc, motionCmdValid, joyEnable, joyPos, joyNeg} = '0;
        {microPulse, leadingEncMode, windingEnable, currentReduced} = '0;
        {supplyShort, coilValid0, coilValid1, encPresent, feedbackOn} = '0;
        {go, encBroken, presetStep, presetMicro, presetEnc, steps} = '0;
        {motionCmdCode, cmdTarget, coilR0, coilL0, coilR1, coilL1} = '0;
        {stepDirPos, encDirPos, shiftModeOn, reachOk, rst} = '1;
        {setSpeed, shiftTarget} = {16'h0010, 32'h32};
        tick(2);
        rst = 1'b0;
        chk("progress word", 32'h20, command_progress_word);
        chk("power", PWR_OFF, winding_power_state);
        chk("encoder", ENC_ABSENT, encoder_health_state);
        chk("coils", 32'h0, coil_connection_state);
        {windingEnable, encPresent} = 2'h3;
        move(CMD_ABS_MOVE, 8'h14);
        chk("running", 32'h11, command_progress_word[4:0]);
        while (stepsSeen < 8 || stepPulse) tick(1);
        {setZeroCmd, z} = {1'b1, stepsSeen};
        tick(1);
        {setZeroCmd, encSeen} = '0;
        chk("zeroed", 32'h0, primary_position_count);
        chk("target", 32'h14 - z, moveTarget);
        chk("shift dest", 32'h32 - z, shiftDest);
        settle_move;
        chk("end", 32'h14 - z, primary_position_count);
        chk("result", 32'h2, command_progress_word[5:4]);
        chk("flags", 32'h7, seen);
        chk("enc ok", ENC_OK, encoder_health_state);
        $display("zero test done");
        move(CMD_REL_SHIFT, 8'h14);
        while (stepsSeen < 6 || stepPulse) tick(1);
        {presetStep, presetMicro, presetEnc} = {32'h64, 16'h5, 32'h22B};
        {preset_counters_cmd, presetIgnoreEnc, z} = {2'h3, stepsSeen};
        tick(1);
        preset_counters_cmd = 1'b0;
        chk("micro", 32'h5, microstep_count);
        settle_move;
        chk("end", 32'h64 + 32'h14 - z, primary_position_count);
        chk("target", 32'h64 + 32'h14 - z, moveTarget);
        chk("enc kept", encSeen, encoderCount);
        {preset_counters_cmd, presetIgnoreStep, presetIgnoreEnc} = 3'h6;
        tick(1);
        chk("step kept", 32'h64 + 32'h14 - z, primary_position_count);
        chk("enc", 32'h22B, encoderCount);
        setZeroCmd = 1'b1;
        tick(1);
        {setZeroCmd, preset_counters_cmd, presetIgnoreStep} = '0;
        chk("zero wins", 32'h0, encoderCount);
        $display("preset test done");
        {encBroken, reachOk} = 2'h2;
        move(CMD_ABS_MOVE, 8'h14);
        settle_move;
        chk("result", 32'h0, command_progress_word[5:4]);
        chk("enc", ENC_DEFECT, encoder_health_state);
        feedbackOn = 1'b1;
        tick(3);
        chk("enc", ENC_UNKNOWN, encoder_health_state);
        for (int c = 1; c <= 8; c++) begin
            move(c[3:0], 8'h0);
            chk("code", {1'b1, c[3:0]}, command_progress_word[4:0]);
        end
        $display("motion test done");
        {joyEnable, joyPos} = 2'h3;
        repeat (8) if (issueCmdValid !== 1'b1) tick(1);
        chk("joystick", CMD_RUN_POS, issueCmdCode);
        tick(1);
        chk("joy cmd", 32'h13, command_progress_word[4:0]);
        joyPos = 1'b0;
        repeat (8) if (issueCmdValid !== 1'b1) tick(1);
        chk("joystick", CMD_SMOOTH, issueCmdCode);
        tick(1);
        joyNeg = 1'b1;
        repeat (8) if (issueCmdValid !== 1'b1) tick(1);
        chk("joystick", CMD_RUN_NEG, issueCmdCode);
        for (int i = 0; i < 4; i++) begin
            {windingEnable, currentReduced, supplyShort} = PWR_IN[i];
            tick(2);
            chk("power", PWR_EXP[i], winding_power_state);
        end
        {coilR0, coilL0, coilR1, coilL1} = {32'h0, 16'hFFFF, 16'h0100};
        {coilValid0, coilValid1} = 2'h3;
        tick(2);
        chk("coils", {COIL_OPEN, COIL_SHORTED}, coil_connection_state);
        {leadingEncMode, microPulse} = 2'h3;
        tick(3);
        chk("micro", 32'h0, microstep_count);
        chk("lead step", 32'h0, primary_position_count);
        $display("status test done");
        complete_run;
    end

    // tests need a few hundred cycles; this leaves wide margin
    initial begin
        #400000;
        fail_count++;
        complete_run;
    end
endmodule : tb
